// file: hw/ovpm_ctrl.sv
// control, status and interrupt logic of the over-voltage monitor
// Function
// - enable clear powers down comparator and dac
// - hysteresis enable bit drives comparator hysteresis
// - dac reference: supply or external pin
// - debounce code picks 0, 8, 16, 32
// - comparator result readable, read only
// - calibration reference from negative or positive
// - dac code 8 bit, reset zero
// - calibration mode bit enters offset calibration
// - comparator weighs pin against dac level
// - over-voltage event raises masked interrupt
`timescale 1ns/1ps
`include "ovpm_defines.svh"

module ovpm_ctrl #(
  parameter int DEB_CNT_W = 6
) (
  input  wire logic                       clk_sys_in,
  input  wire logic                       rst_in,
  input  wire logic [`OVPM_ADDR_W-1:0]    addr_in,
  input  wire logic [7:0]                 wdata_in,
  input  wire logic                       wr_in,
  input  wire logic                       rd_in,
  output logic [7:0]                      rdata_out,
  input  wire logic                       comp_raw_in,
  output ovpm_pkg::ovpm_analog_type       analog_out,
  output logic                            irq_out
);

  // field width follows the trim bit positions
  localparam int TRIM_W = `OVPM_TRIM_HI - `OVPM_TRIM_LO + 1;

  // register state
  logic                     enable_ff;
  logic                     hys_ff;
  logic                     refsel_ff;
  ovpm_pkg::ovpm_deb_type   deb_ff;
  logic                     calmode_ff;
  logic                     calref_ff;
  logic [TRIM_W-1:0]        trim_ff;
  logic [7:0]               dac_ff;
  logic [`OVPM_IRQ_W-1:0]   stat_ff;
  logic [`OVPM_IRQ_W-1:0]   mask_ff;
  logic [7:0]               rdata_ff;
  logic                     irq_ff;

  // registered copies of the analog settings
  logic                     power_out_ff;
  logic                     hys_out_ff;
  logic                     ref_out_ff;
  logic                     cal_out_ff;
  logic                     calref_out_ff;
  logic [TRIM_W-1:0]        trim_out_ff;
  logic [7:0]               dac_out_ff;

  // input synchroniser and edge tracking
  logic                     raw_meta_ff;
  logic                     raw_sync_ff;
  logic                     result_prev_ff;
  logic                     result;

  // decoded write strobes, one per register
  logic                     wr_ctrl;
  logic                     wr_trim;
  logic                     wr_dac;
  logic                     wr_stat;
  logic                     wr_mask;

  logic [7:0]               ctrl_view;
  logic [7:0]               trim_view;
  logic [`OVPM_IRQ_W-1:0]   event_vec;
  logic [`OVPM_IRQ_W-1:0]   clr_vec;
  logic [`OVPM_IRQ_W-1:0]   nxt_stat;
  logic [`OVPM_IRQ_W-1:0]   pending;

  // write strobe decode shared by every register
  function automatic logic wr_hit(input logic                    wr,
                                  input logic [`OVPM_ADDR_W-1:0] a,
                                  input logic [`OVPM_ADDR_W-1:0] off);
    wr_hit = wr && (a == off);
  endfunction

  // edge of the filtered result; none while calibrating
  function automatic logic edge_seen(input logic cur,
                                     input logic prev,
                                     input logic cal);
    edge_seen = cur && !prev && !cal;
  endfunction

  // one decoded strobe per register keeps the blocks below short
  always_comb begin
    wr_ctrl = wr_hit(wr_in, addr_in, `OVPM_OFF_CTRL);
    wr_trim = wr_hit(wr_in, addr_in, `OVPM_OFF_TRIM);
    wr_dac  = wr_hit(wr_in, addr_in, `OVPM_OFF_DAC);
    wr_stat = wr_hit(wr_in, addr_in, `OVPM_OFF_IRQ_STAT);
    wr_mask = wr_hit(wr_in, addr_in, `OVPM_OFF_IRQ_MASK);
  end

  // protection enable; clear powers the front end down
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      enable_ff <= 1'b0;
    end else if (wr_ctrl) begin
      enable_ff <= wdata_in[`OVPM_BIT_EN];
    end
  end

  // hysteresis enable, passed on only while powered
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      hys_ff <= 1'b0;
    end else if (wr_ctrl) begin
      hys_ff <= wdata_in[`OVPM_BIT_HYS];
    end
  end

  // dac reference: supply or external pin
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      refsel_ff <= 1'b0;
    end else if (wr_ctrl) begin
      refsel_ff <= wdata_in[`OVPM_BIT_REFSEL];
    end
  end

  // debounce code; the hold count lives in the filter
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      deb_ff <= ovpm_pkg::OVPM_DEB_NONE;
    end else if (wr_ctrl) begin
      deb_ff <= ovpm_pkg::ovpm_deb_type'(
                  wdata_in[`OVPM_DEB_HI:`OVPM_DEB_LO]);
    end
  end

  // calibration mode; the result bit itself is not writable
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      calmode_ff <= 1'b0;
    end else if (wr_trim) begin
      calmode_ff <= wdata_in[`OVPM_BIT_CALMODE];
    end
  end

  // calibration reference input
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      calref_ff <= 1'b0;
    end else if (wr_trim) begin
      calref_ff <= wdata_in[`OVPM_BIT_CALREF];
    end
  end

  // trim code; reset leaves it mid-scale
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      trim_ff <= `OVPM_TRIM_RST;
    end else if (wr_trim) begin
      trim_ff <= wdata_in[`OVPM_TRIM_HI:`OVPM_TRIM_LO];
    end
  end

  // threshold dac code
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      dac_ff <= `OVPM_DAC_RST;
    end else if (wr_dac) begin
      dac_ff <= wdata_in;
    end
  end

  // interrupt mask
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      mask_ff <= '0;
    end else if (wr_mask) begin
      mask_ff <= wdata_in[`OVPM_IRQ_W-1:0];
    end
  end

  // comparator output comes from the analog domain: two flops first
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      raw_meta_ff <= 1'b0;
      raw_sync_ff <= 1'b0;
    end else begin
      raw_meta_ff <= comp_raw_in;
      raw_sync_ff <= raw_meta_ff;
    end
  end

  // filtered result; a powered-down comparator reads low
  ovpm_debounce #(
    .CNT_W     (DEB_CNT_W)
  ) u_debounce (
    .clk_sys_in(clk_sys_in),
    .rst_in    (rst_in),
    .sample_in (raw_sync_ff & enable_ff),
    .mode_in   (deb_ff),
    .level_out (result)
  );

  // last result, for edge detection
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      result_prev_ff <= 1'b0;
    end else begin
      result_prev_ff <= result;
    end
  end

  // events: rise of the result is over-voltage, fall is recovery;
  // calibration sweeps toggle the result, so they raise no event
  always_comb begin
    event_vec = '0;
    event_vec[`OVPM_IRQ_OVER] = edge_seen(result, result_prev_ff,
                                          calmode_ff);
    event_vec[`OVPM_IRQ_FALL] = edge_seen(~result, ~result_prev_ff,
                                          calmode_ff);
  end

  // write one to clear, only on a write to the status index
  always_comb begin
    clr_vec = '0;
    if (wr_stat) begin
      clr_vec = wdata_in[`OVPM_IRQ_W-1:0];
    end
  end

  // sticky status; a same-cycle event wins over its clear
  always_comb begin
    nxt_stat = (stat_ff & ~clr_vec) | event_vec;
  end

  // status register
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      stat_ff <= '0;
    end else begin
      stat_ff <= nxt_stat;
    end
  end

  // unmasked status as it will stand after this edge
  always_comb begin
    pending = nxt_stat & mask_ff;
  end

  // level interrupt from a flop; rises with its status bit
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |pending;
    end
  end

  // register views for readback, unused bits read zero
  always_comb begin
    ctrl_view = '0;
    ctrl_view[`OVPM_BIT_EN]     = enable_ff;
    ctrl_view[`OVPM_BIT_HYS]    = hys_ff;
    ctrl_view[`OVPM_BIT_REFSEL] = refsel_ff;
    ctrl_view[`OVPM_DEB_HI:`OVPM_DEB_LO] = deb_ff;
    trim_view = '0;
    trim_view[`OVPM_BIT_RESULT]  = result;
    trim_view[`OVPM_BIT_CALMODE] = calmode_ff;
    trim_view[`OVPM_BIT_CALREF]  = calref_ff;
    trim_view[`OVPM_TRIM_HI:`OVPM_TRIM_LO] = trim_ff;
  end

  // read data stands the cycle after the strobe only
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_ff <= 8'h00;
    end else if (rd_in) begin
      unique case (addr_in)
        `OVPM_OFF_CTRL:     rdata_ff <= ctrl_view;
        `OVPM_OFF_TRIM:     rdata_ff <= trim_view;
        `OVPM_OFF_DAC:      rdata_ff <= dac_ff;
        `OVPM_OFF_IRQ_STAT: rdata_ff <= 8'(stat_ff);
        `OVPM_OFF_IRQ_MASK: rdata_ff <= 8'(mask_ff);
        default:            rdata_ff <= 8'h00;
      endcase
    end else begin
      rdata_ff <= 8'h00;
    end
  end

  // gated settings: enable low forces power, hysteresis, cal off
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      power_out_ff <= 1'b0;
      hys_out_ff   <= 1'b0;
      cal_out_ff   <= 1'b0;
    end else begin
      power_out_ff <= enable_ff;
      hys_out_ff   <= hys_ff & enable_ff;
      cal_out_ff   <= calmode_ff & enable_ff;
    end
  end

  // reference selections pass through one cycle late
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      ref_out_ff    <= 1'b0;
      calref_out_ff <= 1'b0;
    end else begin
      ref_out_ff    <= refsel_ff;
      calref_out_ff <= calref_ff;
    end
  end

  // trim and dac codes; zero while reset is held
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      trim_out_ff <= '0;
      dac_out_ff  <= '0;
    end else begin
      trim_out_ff <= trim_ff;
      dac_out_ff  <= dac_ff;
    end
  end

  // outputs straight from their flops
  assign rdata_out  = rdata_ff;
  assign irq_out    = irq_ff;
  assign analog_out = '{
    power_on:          power_out_ff,
    hysteresis_enable: hys_out_ff,
    dac_ref_select:    ref_out_ff,
    offset_cal_mode:   cal_out_ff,
    cal_ref_select:    calref_out_ff,
    offset_trim_code:  trim_out_ff,
    dac_level:         dac_out_ff
  };

endmodule

// file: hw/ovpm_defines.svh
// register offsets, field positions, reset values and timing counts
`ifndef OVPM_DEFINES_SVH
`define OVPM_DEFINES_SVH

`define OVPM_ADDR_W        4
`define OVPM_OFF_CTRL      4'h0
`define OVPM_OFF_TRIM      4'h1
`define OVPM_OFF_DAC       4'h2
`define OVPM_OFF_IRQ_STAT  4'h3
`define OVPM_OFF_IRQ_MASK  4'h4

`define OVPM_BIT_EN        5
`define OVPM_BIT_HYS       4
`define OVPM_BIT_REFSEL    2
`define OVPM_DEB_HI        1
`define OVPM_DEB_LO        0

`define OVPM_BIT_RESULT    7
`define OVPM_BIT_CALMODE   6
`define OVPM_BIT_CALREF    5
`define OVPM_TRIM_HI       4
`define OVPM_TRIM_LO       0

`define OVPM_CTRL_RST      8'h00
`define OVPM_TRIM_RST      5'h10
`define OVPM_DAC_RST       8'h00

`define OVPM_IRQ_OVER      0
`define OVPM_IRQ_FALL      1
`define OVPM_IRQ_W         2

`define OVPM_DEB_LEN1      6'h08
`define OVPM_DEB_LEN2      6'h10
`define OVPM_DEB_LEN3      6'h20

`endif

// file: hw/ovpm_pkg.sv
// types shared by the over-voltage monitor control logic
package ovpm_pkg;
  typedef enum logic [1:0] {
    OVPM_DEB_NONE = 2'b00,
    OVPM_DEB_8    = 2'b01,
    OVPM_DEB_16   = 2'b10,
    OVPM_DEB_32   = 2'b11
  } ovpm_deb_type;

  // settings carried to the analog comparator and dac front end
  typedef struct packed {
    logic       power_on;
    logic       hysteresis_enable;
    logic       dac_ref_select;
    logic       offset_cal_mode;
    logic       cal_ref_select;
    logic [4:0] offset_trim_code;
    logic [7:0] dac_level;
  } ovpm_analog_type;
endpackage

// file: hw/ovpm_debounce.sv
// debounce filter for the raw comparator output
`timescale 1ns/1ps
`include "ovpm_defines.svh"

module ovpm_debounce #(
  parameter int CNT_W = 6
) (
  input  wire logic                  clk_sys_in,
  input  wire logic                  rst_in,
  input  wire logic                  sample_in,
  input  wire ovpm_pkg::ovpm_deb_type mode_in,
  output logic                       level_out
);

  logic [CNT_W-1:0] cnt_ff;
  logic             level_ff;
  logic [CNT_W-1:0] target;

  // hold lengths in clock periods; the stated 7-8 window lands on 8
  always_comb begin
    unique case (mode_in)
      ovpm_pkg::OVPM_DEB_NONE: target = '0;
      ovpm_pkg::OVPM_DEB_8:    target = CNT_W'(`OVPM_DEB_LEN1);
      ovpm_pkg::OVPM_DEB_16:   target = CNT_W'(`OVPM_DEB_LEN2);
      ovpm_pkg::OVPM_DEB_32:   target = CNT_W'(`OVPM_DEB_LEN3);
    endcase
  end

  // count while the sample differs, restart on any bounce
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_ff   <= '0;
      level_ff <= 1'b0;
    end else if (sample_in == level_ff) begin
      cnt_ff <= '0;
    end else if (mode_in == ovpm_pkg::OVPM_DEB_NONE) begin
      level_ff <= sample_in;
      cnt_ff   <= '0;
    end else if (cnt_ff + CNT_W'(1) >= target) begin
      level_ff <= sample_in;
      cnt_ff   <= '0;
    end else begin
      cnt_ff <= cnt_ff + CNT_W'(1);
    end
  end

  assign level_out = level_ff;

endmodule

// file: testbench/ovpm_ctrl_checker.sv
// port assertions for the over-voltage monitor control block
`timescale 1ns/1ps
module ovpm_ctrl_checker #(
  parameter int DEB_CNT_W = 6
) (
  input wire logic                      clk_sys_in,
  input wire logic                      rst_in,
  input wire logic [3:0]                addr_in,
  input wire logic [7:0]                wdata_in,
  input wire logic                      wr_in,
  input wire logic                      rd_in,
  input wire logic [7:0]                rdata_out,
  input wire logic                      comp_raw_in,
  input wire ovpm_pkg::ovpm_analog_type analog_out,
  input wire logic                      irq_out
);
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (rst_in);
  // register writes, one each for the control and trim targets
  sequence s_wr_ctrl;
    wr_in && addr_in == 4'h0;
  endsequence
  sequence s_wr_trim;
    wr_in && addr_in == 4'h1;
  endsequence
  a_rd_idle: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
    else $error("read data not zero outside a read");
  a_power_set: assert property (s_wr_ctrl |-> ##2
    analog_out.power_on == $past(wdata_in[5], 2))
    else $error("enable not applied");
  a_hys_set: assert property (s_wr_ctrl |-> ##2
    analog_out.hysteresis_enable == ($past(wdata_in[5], 2) &
    $past(wdata_in[4], 2))) else $error("hysteresis not applied");
  a_ref_set: assert property (s_wr_ctrl |-> ##2
    analog_out.dac_ref_select == $past(wdata_in[2], 2))
    else $error("dac reference not applied");
  a_dac_set: assert property (wr_in && addr_in == 4'h2 |-> ##2
    analog_out.dac_level == $past(wdata_in, 2))
    else $error("dac level not applied");
  a_trim_set: assert property (s_wr_trim |-> ##2
    analog_out.offset_trim_code == $past(wdata_in[4:0], 2) &&
    analog_out.cal_ref_select == $past(wdata_in[5], 2))
    else $error("trim or cal reference not applied");
  a_cal_off: assert property (!analog_out.power_on |->
    !analog_out.offset_cal_mode) else $error("cal mode while off");
  a_irq_mask: assert property (wr_in && addr_in == 4'h4 &&
    wdata_in[1:0] == 2'b00 |-> ##2 !irq_out)
    else $error("irq high with all masked");
endmodule
bind ovpm_ctrl ovpm_ctrl_checker #(.DEB_CNT_W(DEB_CNT_W)) chk (
  .clk_sys_in, .rst_in, .addr_in, .wdata_in, .wr_in, .rd_in,
  .rdata_out, .comp_raw_in, .analog_out, .irq_out);

// file: testbench/ovpm_front_model.sv
// behavioural comparator and threshold dac in front of the block
`timescale 1ns/1ps
module ovpm_front_model #(
  parameter int CAL_OFS = 13
) (
  input  wire ovpm_pkg::ovpm_analog_type analog_in,
  input  wire logic [7:0]                pin_level_in,
  input  wire logic [7:0]                ext_ref_in,
  output logic                           comp_raw_out
);
  logic [15:0] thr;
  // threshold is reference times code over 256
  always_comb begin
    thr = (analog_in.dac_ref_select ? ext_ref_in : 8'hff) *
      analog_in.dac_level >> 8;
    if (analog_in.hysteresis_enable) begin
      thr = thr + 16'h0002;
    end
  end
  // powered down reads low; cal mode watches the trim and cal reference only
  always_comb begin
    if (!analog_in.power_on) begin
      comp_raw_out = 1'b0;
    end else if (analog_in.offset_cal_mode) begin
      comp_raw_out = (analog_in.offset_trim_code >= CAL_OFS) ^
        ~analog_in.cal_ref_select;
    end else begin
      comp_raw_out = {8'h00, pin_level_in} > thr;
    end
  end
endmodule

// file: testbench/ovpm_ctrl_test.sv
// self-checking bench for the over-voltage monitor control block
`timescale 1ns/1ps
module ovpm_ctrl_test;
  logic                      clk_sys_in   = 1'b0;
  logic                      rst_in       = 1'b1;
  logic [3:0]                addr_in      = 4'h0;
  logic [7:0]                wdata_in     = 8'h00;
  logic                      wr_in        = 1'b0;
  logic                      rd_in        = 1'b0;
  logic [7:0]                pin          = 8'h00;
  logic [7:0]                rdata_out;
  logic                      comp_raw_in;
  logic                      irq_out;
  ovpm_pkg::ovpm_analog_type analog_out;
  int                        err_total    = 0;
  int                        total_checks = 0;
  int                        seed         = 65530;
  int                        n;
  logic [7:0]                v;
  logic [7:0]                d;
  logic [4:0]                lo;
  logic [4:0]                hi;

  ovpm_ctrl #(.DEB_CNT_W(6)) uut (.clk_sys_in, .rst_in, .addr_in,
    .wdata_in, .wr_in, .rd_in, .rdata_out, .comp_raw_in, .analog_out,
    .irq_out);
  ovpm_front_model #(.CAL_OFS(13)) fe (.analog_in(analog_out),
    .pin_level_in(pin), .ext_ref_in(8'h40), .comp_raw_out(comp_raw_in));

  // free-running system clock
  always #50 clk_sys_in = ~clk_sys_in;

  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // an idle cycle follows each strobe, so no strobe is set twice at once
  task automatic wr(input logic [3:0] a, input logic [7:0] dt);
    addr_in <= a;
    wdata_in <= dt;
    wr_in <= 1'b1;
    @(posedge clk_sys_in);
    wr_in <= 1'b0;
    @(posedge clk_sys_in);
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] dt);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_sys_in);
    rd_in <= 1'b0;
    #1 dt = rdata_out;
    @(posedge clk_sys_in);
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] g;
    rd(a, g);
    chk("register", e, g);
  endtask
  task automatic irq_chk(input logic e);
    repeat (2) @(posedge clk_sys_in);
    #1 chk("irq", {7'h00, e}, {7'h00, irq_out});
  endtask
  // one trim step: write, let it settle through sync, read result
  task automatic cal_step(input logic [4:0] t, output logic r);
    logic [7:0] g;
    wr(4'h1, {3'b011, t});
    repeat (6) @(posedge clk_sys_in);
    rd(4'h1, g);
    r = g[7];
  endtask
  task automatic sweep(input logic [4:0] s, input logic up,
                       output logic [4:0] f);
    logic p;
    logic r;
    f = s;
    cal_step(s, p);
    r = p;
    while (r === p && f !== (up ? 5'h1f : 5'h00)) begin
      f = up ? f + 5'h01 : f - 5'h01;
      cal_step(f, r);
    end
  endtask
  function automatic logic lat_ok(input int m, input int c);
    int len;
    len = (m == 0) ? 0 : (4 << m);
    return c >= len && c <= len + 10;
  endfunction
  function automatic logic [4:0] avg(input logic [4:0] a, b);
    logic [5:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[5:1];
  endfunction

  // watchdog at 5000 cycles, well past the thousand or so cycles the run needs
  initial begin
    #(5000 * 100);
    err_total++;
    report_and_stop();
  end

  // main sequence
  initial begin
    repeat (10) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    rdchk(4'h0, 8'h00);
    rdchk(4'h1, 8'h10);
    rdchk(4'h2, 8'h00);
    rdchk(4'h5, 8'h00);
    for (int i = 0; i < 4; i++) begin
      d = 8'($random(seed));
      wr(4'h0, d);
      rdchk(4'h0, d & 8'h37);
    end
    wr(4'h0, 8'h00);
    for (int i = 0; i < 4; i++) begin
      d = 8'($random(seed));
      wr(4'h1, d);
      rdchk(4'h1, d & 8'h7f);
    end
    wr(4'h1, 8'h10);
    wr(4'h2, 8'h80);
    wr(4'h4, 8'h01);
    // each debounce code: a hold passes; the three nonzero codes also ignore a short bounce
    for (int m = 0; m < 4; m++) begin
      wr(4'h3, 8'h03);
      wr(4'h0, 8'h20 | m[7:0]);
      if (m > 0) begin
        pin <= 8'hc0;
        repeat (4) @(posedge clk_sys_in);
        pin <= 8'h00;
      end
      repeat (40) @(posedge clk_sys_in);
      rd(4'h1, v);
      chk("bounce", 8'h00, {7'h00, v[7]});
      pin <= 8'hc0;
      n = 0;
      v = 8'h00;
      while (v[7] !== 1'b1 && n < 80) begin
        rd(4'h1, v);
        n += 2;
      end
      chk("latency", 8'h01, {7'h00, lat_ok(m, n)});
      irq_chk(1'b1);
      wr(4'h0, 8'h00);
      repeat (40) @(posedge clk_sys_in);
      rd(4'h1, v);
      chk("off result", 8'h00, {7'h00, v[7]});
      pin <= 8'h00;
    end
    // mask and sticky clear of the falling event
    wr(4'h4, 8'h02);
    irq_chk(1'b1);
    wr(4'h4, 8'h00);
    irq_chk(1'b0);
    wr(4'h4, 8'h03);
    wr(4'h3, 8'h03);
    irq_chk(1'b0);
    rdchk(4'h3, 8'h00);
    // reset again in mid-run: written values must fall back
    wr(4'h1, 8'h6f);
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    rdchk(4'h2, 8'h00);
    rdchk(4'h1, 8'h10);
    // offset calibration sweep, hysteresis left cleared
    wr(4'h0, 8'h20);
    sweep(5'h00, 1'b1, lo);
    sweep(5'h1f, 1'b0, hi);
    chk("cal low", 8'h0d, {3'b000, lo});
    chk("cal high", 8'h0c, {3'b000, hi});
    wr(4'h1, {3'b011, avg(lo, hi)});
    #1 chk("trim out", {3'b000, avg(5'h0d, 5'h0c)},
      {3'b000, analog_out.offset_trim_code});
    chk("cal mode", 8'h01, {7'h00, analog_out.offset_cal_mode});
    report_and_stop();
  end
endmodule
